// File: rtl/wdog_pkg.sv
package wdog_pkg;

  // ************************************************************
  // register map (byte addresses, 32-bit aligned words)
  // ************************************************************
  localparam logic [11:0] SERVICE_OFS = 12'h000;
  localparam logic [11:0] OPTION_OFS  = 12'h004;
  localparam logic [11:0] TESTREG_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS  = 12'h00C;

  localparam logic [7:0] ARM_VAL   = 8'h55;
  localparam logic [7:0] CLEAR_VAL = 8'hAA;

  // option fields: rate in [1:0], monitor enable in [2]
  localparam int RATE_LO_POS = 0;
  localparam int RATE_HI_POS = 1;
  localparam int MON_EN_POS  = 2;
  localparam int RST_DIS_POS = 0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          PRESCALE_DEFAULT = 32768;
  localparam logic [2:0]  DRIVE_LAST  = 3'h3;
  localparam logic [2:0]  SAMPLE_LAST = 3'h3;
  localparam logic [6:0]  WIN_LAST    = 7'h40;
  localparam logic [6:0]  DIV_RATE0   = 7'h01;
  localparam logic [6:0]  DIV_RATE1   = 7'h04;
  localparam logic [6:0]  DIV_RATE2   = 7'h10;
  localparam logic [6:0]  DIV_RATE3   = 7'h40;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRIVE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_HOLD  = 2'b11
  } seq_type;

  typedef enum logic [1:0] {
    VEC_NORMAL = 2'b00,
    VEC_WDOG   = 2'b01,
    VEC_CMON   = 2'b10
  } vec_type;

  typedef struct packed {
    logic [1:0]  sync_sm;
    logic [1:0]  sync_cfg;
    logic [1:0]  sync_cm;
    logic [1:0]  sync_pin;
    seq_type     fsm;
    logic [2:0]  cnt;
    logic [14:0] presc;
    logic [6:0]  div;
    logic        armed;
    logic [1:0]  rate;
    logic        rate_done;
    logic [6:0]  win;
    logic        mon_en;
    logic        rst_dis;
    logic        special;
    logic        wd_en;
    logic        wd_pend;
    logic        cm_pend;
    logic        ext;
    vec_type     vec;
    logic        vec_valid;
    logic        pin_out;
    logic        oe_n;
    logic        sysrst;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_type;

endpackage : wdog_pkg

// File: rtl/watchdog_clock_monitor_reset.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module watchdog_clock_monitor_reset
  import wdog_pkg::*;
#(
  parameter int PRESCALE_PERIOD = PRESCALE_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        special_mode_pin,
  input  wire logic        watchdog_disable_cfg,
  input  wire logic        clock_monitor_fail,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n,
  output logic             system_reset,
  output vec_type          vector_sel,
  output logic             vector_valid
);

  localparam logic [14:0] PRESC_LAST = 15'(PRESCALE_PERIOD - 1);

  // ************************************************************
  // state
  // ************************************************************
  state_type r;
  state_type n;

  logic       tick;
  logic       acc;
  logic       wr;
  logic       wd_to;
  logic       cm_to;
  logic       pin_low;
  logic       rate_ok;
  logic [6:0] div_sel;

  localparam state_type RESET_STATE = '{
    sync_sm:   2'h0,
    sync_cfg:  2'h0,
    sync_cm:   2'h0,
    sync_pin:  2'h0,
    fsm:       ST_DRIVE,
    cnt:       3'h0,
    presc:     15'h0000,
    div:       7'h00,
    armed:     1'b0,
    rate:      2'h0,
    rate_done: 1'b0,
    win:       7'h00,
    mon_en:    1'b0,
    rst_dis:   1'b1,
    special:   1'b0,
    wd_en:     1'b0,
    wd_pend:   1'b0,
    cm_pend:   1'b0,
    ext:       1'b0,
    vec:       VEC_NORMAL,
    vec_valid: 1'b0,
    pin_out:   1'b0,
    oe_n:      1'b0,
    sysrst:    1'b1,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h0000_0000
  };

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n = r;
    n.sync_sm  = {r.sync_sm[0], special_mode_pin};
    n.sync_cfg = {r.sync_cfg[0], watchdog_disable_cfg};
    n.sync_cm  = {r.sync_cm[0], clock_monitor_fail};
    n.sync_pin = {r.sync_pin[0], reset_pin_in};
    pin_low    = ~r.sync_pin[1];

    // prescaler is never cleared by servicing
    tick    = (r.presc == PRESC_LAST);
    n.presc = tick ? 15'h0000 : r.presc + 15'h0001;

    case (r.rate)
      2'b00:   div_sel = DIV_RATE0;
      2'b01:   div_sel = DIV_RATE1;
      2'b10:   div_sel = DIV_RATE2;
      default: div_sel = DIV_RATE3;
    endcase

    // the first tick after a clear may come almost at once, so one
    // extra tick is counted: never short, at most one tick long
    wd_to = r.wd_en & ~r.rst_dis & tick & (r.div == div_sel);
    cm_to = r.mon_en & ~r.rst_dis & r.sync_cm[1];

    // bus: one wait state, answer registered
    acc       = psel & penable & r.pready;
    wr        = acc & pwrite & (r.fsm == ST_IDLE);
    n.pready  = psel & penable & ~r.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (psel & penable & ~r.pready) begin
      if (paddr == SERVICE_OFS) begin
        n.prdata = 32'h0000_0000;
      end else if (paddr == OPTION_OFS) begin
        n.prdata[RATE_HI_POS:RATE_LO_POS] = r.rate;
        n.prdata[MON_EN_POS] = r.mon_en;
      end else if (paddr == TESTREG_OFS) begin
        n.prdata[RST_DIS_POS] = r.rst_dis;
      end else if (paddr == STATUS_OFS) begin
        n.prdata[5:0] = {r.vec_valid, r.vec, r.ext, r.cm_pend, r.wd_pend};
      end else begin
        n.pslverr = 1'b1;
      end
    end

    rate_ok = r.special | (~r.rate_done & (r.win < WIN_LAST));

    case (r.fsm)
      ST_IDLE: begin
        if (r.win != WIN_LAST) begin
          n.win = r.win + 7'h01;
        end
        if (r.wd_en & tick) begin
          n.div = r.div + 7'h01;
        end
        if (wr && paddr == SERVICE_OFS) begin
          if (pwdata[7:0] == ARM_VAL) begin
            n.armed = 1'b1;
          end else if (pwdata[7:0] == CLEAR_VAL && r.armed) begin
            n.armed = 1'b0;
            n.div   = 7'h00;
          end
          // an unarmed clear, or any other value, changes nothing
        end
        if (wr && paddr == OPTION_OFS) begin
          n.mon_en = pwdata[MON_EN_POS];
          if (rate_ok) begin
            n.rate      = pwdata[RATE_HI_POS:RATE_LO_POS];
            n.rate_done = 1'b1;
          end
        end
        if (wr && paddr == TESTREG_OFS) begin
          n.rst_dis = r.special & pwdata[RST_DIS_POS];
        end
        if (wd_to | cm_to | pin_low) begin
          // every cause takes the same path
          n.fsm       = ST_DRIVE;
          n.cnt       = 3'h0;
          n.oe_n      = 1'b0;
          n.sysrst    = 1'b1;
          n.vec_valid = 1'b0;
          n.wd_pend   = wd_to;
          n.cm_pend   = cm_to;
          n.ext       = 1'b0;
          n.armed     = 1'b0;
          n.div       = 7'h00;
          n.rate      = 2'h0;
          n.rate_done = 1'b0;
          n.mon_en    = 1'b0;
        end
      end
      ST_DRIVE: begin
        if (r.cnt != DRIVE_LAST) begin
          n.cnt = r.cnt + 3'h1;
        end else if (!(r.cm_pend & r.sync_cm[1])) begin
          // a persisting clock fault keeps the pin low
          n.fsm  = ST_WAIT;
          n.cnt  = 3'h0;
          n.oe_n = 1'b1;
        end
      end
      ST_WAIT: begin
        // two synchroniser stages are added to the two cycles so the
        // level seen is the pin two cycles after release
        if (r.cnt != SAMPLE_LAST) begin
          n.cnt = r.cnt + 3'h1;
        end else begin
          n.fsm = ST_HOLD;
          n.ext = pin_low;
          if (pin_low) begin
            n.wd_pend = 1'b0;
            n.cm_pend = 1'b0;
            n.vec     = VEC_NORMAL;
          end else if (r.cm_pend) begin
            n.vec = VEC_CMON;
          end else if (r.wd_pend) begin
            n.vec = VEC_WDOG;
          end else begin
            n.vec = VEC_NORMAL;
          end
        end
      end
      default: begin
        // wait for the external source to let go
        if (!pin_low) begin
          n.fsm       = ST_IDLE;
          n.sysrst    = 1'b0;
          n.vec_valid = 1'b1;
          n.special   = r.sync_sm[1];
          n.rst_dis   = r.sync_sm[1];
          n.wd_en     = ~r.sync_cfg[1];
          n.win       = 7'h00;
          n.div       = 7'h00;
        end
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign reset_pin_out  = r.pin_out;
  assign reset_pin_oe_n = r.oe_n;
  assign system_reset   = r.sysrst;
  assign vector_sel     = r.vec;
  assign vector_valid   = r.vec_valid;

endmodule : watchdog_clock_monitor_reset

// File: bench/wdog_chk.sv
`timescale 1ns/1ps
module wdog_chk
  import wdog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic system_reset,
  input wire logic vector_valid
);
  // ***
  // checks
  // ***
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence drive_s; !reset_pin_oe_n[*4]; endsequence
  sequence wait_s; (reset_pin_oe_n && system_reset)[*4]; endsequence
  drive_len_a: assert property ($fell(reset_pin_oe_n) |-> drive_s) else $error("drive short");
  wait_len_a: assert property ($rose(reset_pin_oe_n) |-> wait_s) else $error("left early");
  drive_rst_a: assert property (!reset_pin_oe_n |-> system_reset) else $error("stray drive");
  pin_low_a: assert property (!reset_pin_oe_n |-> !reset_pin_out) else $error("pin high");
  vec_ready_a: assert property ($rose(vector_valid) |-> !system_reset && $past(reset_pin_oe_n, 4))
    else $error("vector early");
  ext_start_a: assert property (vector_valid && !reset_pin_in |-> ##[1:4] !reset_pin_oe_n)
    else $error("pin low missed");
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("bus wait");
  apb_pulse_a: assert property (pready |=> !pready) else $error("ready held");
endmodule : wdog_chk

bind watchdog_clock_monitor_reset wdog_chk chk (.pclk, .presetn, .psel, .penable, .pready, .reset_pin_in,
  .reset_pin_out, .reset_pin_oe_n, .system_reset, .vector_valid);

// File: bench/ext_rst_src.sv
`timescale 1ns/1ps
// pulled-up reset line; slow stands for a heavily loaded line
module ext_rst_src (
  input  wire logic pclk,
  input  wire logic oe_n,
  input  wire logic hold,
  input  wire logic slow,
  output logic      pin
);
  logic [2:0] lag_q;
  always_ff @(posedge pclk) lag_q <= !oe_n ? 3'h7 : lag_q - 3'(lag_q != 3'h0);
  assign pin = !(hold || !oe_n || (slow && lag_q != 3'h0));
endmodule : ext_rst_src

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import wdog_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, smode = 0, wd_off = 1, cm_fail = 0;
  logic hold = 0, slow = 0, pready, pslverr, pin, pin_out, oe_n, sys_rst, vvalid, vv_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  vec_type vsel;
  int n_mismatch = 0, samples_checked = 0;
  vec_type vec_q[$];
  logic [32:0] rd_q[$];
  always #12.5 pclk = ~pclk;
  watchdog_clock_monitor_reset #(.PRESCALE_PERIOD(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .special_mode_pin(smode), .watchdog_disable_cfg(wd_off),
    .clock_monitor_fail(cm_fail), .reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .system_reset(sys_rst), .vector_sel(vsel), .vector_valid(vvalid));
  ext_rst_src ext (.pclk, .oe_n, .hold, .slow, .pin);
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic bad(input logic [32:0] g, input logic [32:0] e);
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    n_mismatch++;
  endtask : bad
  task automatic cmp_vec(input vec_type g);
    logic [1:0] e;
    samples_checked++;
    e = vec_q.size() != 0 ? vec_q.pop_front() : 2'h3;
    if (g !== e) bad(33'(g), 33'(e));
  endtask : cmp_vec
  task automatic cmp_rd(input logic [32:0] g);
    logic [32:0] e;
    samples_checked++;
    e = rd_q.size() != 0 ? rd_q.pop_front() : 33'h1FFFFFFFF;
    if (g !== e) bad(g, e);
  endtask : cmp_rd
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic wait_vec(input int n);
    int i;
    for (i = 0; i < n && (vec_q.size() != 0 || vvalid !== 1'b1); i++) @(posedge pclk);
    if (i == n) begin
      bad(33'h0, 33'h1);
      summarize();
    end
  endtask : wait_vec
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!w) rd_q.push_back(e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (i == 20) begin
      bad(33'h0, 33'h1);
      summarize();
    end
  endtask : apb
  always @(posedge pclk) begin
    if (presetn && vvalid === 1'b1 && vv_q !== 1'b1) cmp_vec(vsel);
    vv_q = vvalid;
    if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd({pslverr, prdata});
  end
  initial begin
    void'($urandom(87493));
    vec_q.push_back(VEC_NORMAL);
    cyc(5);
    presetn <= 1'h1;
    wait_vec(60);
    apb(OPTION_OFS, 1'h1, 32'h1, 33'h0);
    apb(OPTION_OFS, 1'h1, 32'h3, 33'h0);
    apb(OPTION_OFS, 1'h0, 32'h0, 33'h1);
    apb(TESTREG_OFS, 1'h1, 32'h1, 33'h0);
    apb(TESTREG_OFS, 1'h0, 32'h0, 33'h0);
    apb(SERVICE_OFS, 1'h0, 32'h0, 33'h0);
    apb(12'h010, 1'h0, 32'h0, 33'h100000000);
    cm_fail <= 1'h1;
    cyc(20);
    cm_fail <= 1'h0;
    wd_off <= 1'h0;
    vec_q.push_back(VEC_NORMAL);
    hold <= 1'h1;
    cyc(14 + $urandom % 8);
    hold <= 1'h0;
    wait_vec(60);
    apb(SERVICE_OFS, 1'h1, 32'(ARM_VAL), 33'h0);
    apb(SERVICE_OFS, 1'h1, 32'(CLEAR_VAL), 33'h0);
    apb(OPTION_OFS, 1'h1, 32'h1, 33'h0);
    repeat (2) begin
      cyc(40);
      apb(SERVICE_OFS, 1'h1, 32'(ARM_VAL), 33'h0);
      apb(STATUS_OFS, 1'h0, 32'h0, 33'h24);
      apb(SERVICE_OFS, 1'h1, 32'(CLEAR_VAL), 33'h0);
    end
    cyc(40);
    apb(SERVICE_OFS, 1'h1, 32'(CLEAR_VAL), 33'h0);
    cyc(12);
    vec_q.push_back(VEC_WDOG);
    // strap must settle before this sequence ends, or the watchdog stays on
    wd_off <= 1'h1;
    wait_vec(45);
    smode <= 1'h1;
    apb(OPTION_OFS, 1'h1, 32'h4, 33'h0);
    vec_q.push_back(VEC_CMON);
    cm_fail <= 1'h1;
    cyc(30);
    samples_checked++;
    if (oe_n !== 1'b0) bad(33'(oe_n), 33'h0);
    cm_fail <= 1'h0;
    wait_vec(60);
    apb(TESTREG_OFS, 1'h0, 32'h0, 33'h1);
    apb(OPTION_OFS, 1'h1, 32'h4, 33'h0);
    cm_fail <= 1'h1;
    cyc(3);
    cm_fail <= 1'h0;
    cyc(20);
    apb(TESTREG_OFS, 1'h1, 32'h0, 33'h0);
    slow <= 1'h1;
    vec_q.push_back(VEC_NORMAL);
    cm_fail <= 1'h1;
    cyc(3);
    cm_fail <= 1'h0;
    wait_vec(60);
    summarize();
  end
endmodule : tb
